// ---- src/vlg_regs.sv ----
// Purpose: level, gain and standard control registers of a video encoder
// Assumes: classic wishbone slave, 20 MHz clk_i, synchronous reset
// Notes:   real-time control lanes arrive from another clock domain
//
// Function
// [RULE1] cr gain: 8 low bits plus blank bit7
// [RULE2] cr code zero gives zero V contribution
// [RULE3] cr code 129 nominal in SECAM
// [RULE4] cb gain msb is black-level register bit7
// [RULE5] field parity enable gates odd/even input
// [RULE6] 6-bit black level field, linear steps
// [RULE7] software programs black level 58 or 51
// [RULE8] phase reset enable gates phase reset input
// [RULE9] 6-bit blanking level, resets to 35h
// [RULE10] software programs blanking 46 or 53
// [RULE11] 2-bit cross-color filter select, 00 off
// [RULE12] 6-bit vertical blanking interval level
// [RULE13] rgb dac down bit, resets to 1
// [RULE14] composite dac down bit, resets to 0
// [RULE15] pal phase invert only with rt enabled
// [RULE16] luma gain select 100 or 92.5 IRE
// [RULE17] secam bit; software clears pal select
// [RULE18] chroma bandwidth select, resets to standard
// [RULE19] pal select bit, resets to PAL
// [RULE20] line length 864 or 858 pixel clocks
// [RULE21] subcarrier real-time control enable, resets off
// [RULE22] 7-bit burst amplitude field
// [RULE23] burst amplitude resets to 2Fh
//
// Added by the designer: the Wishbone register port.
`timescale 1ns/100ps

module vlg_regs
  import vlg_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // wishbone slave
  input  wire logic               cyc_i,
  input  wire logic               stb_i,
  input  wire logic               we_i,
  input  wire logic [ADR_W-1:0]   adr_i,
  input  wire logic [3:0]         sel_i,
  input  wire logic [31:0]        dat_i,
  output logic      [31:0]        dat_o,
  output logic                    ack_o,
  // real-time control lanes from the external decoder
  input  wire logic [RTC_W-1:0]   realtime_control_input_i,
  // control outputs to the encoding datapath
  output logic      [8:0]         cr_chroma_gain_o,
  output logic      [8:0]         cb_chroma_gain_o,
  output logic      [5:0]         black_level_o,
  output logic      [5:0]         blanking_level_o,
  output logic      [5:0]         vbi_blanking_level_o,
  output logic      [1:0]         cross_color_filter_select_o,
  output logic                    rgb_dac_down_o,
  output logic                    composite_dac_down_o,
  output logic                    luma_gain_select_o,
  output logic                    secam_enable_o,
  output logic                    chroma_bandwidth_select_o,
  output logic                    pal_enable_o,
  output logic      [9:0]         line_pixels_o,
  output logic      [6:0]         burst_amplitude_o,
  output logic                    subcarrier_rt_enable_o,
  output logic                    field_parity_o,
  output logic                    phase_reset_o,
  output logic                    pal_switch_invert_o
);

  // *****************************************************************
  // register storage
  // *****************************************************************
  logic [REG_W-1:0] cb_low_r;
  logic [REG_W-1:0] cr_low_r;
  logic [REG_W-1:0] black_cb_r;
  logic [REG_W-1:0] blank_cr_r;
  logic [REG_W-1:0] filter_vbi_r;
  logic [REG_W-1:0] std_dac_r;
  logic [REG_W-1:0] burst_rt_r;

  logic             ack_r;
  logic [31:0]      dat_r;
  logic [31:0]      dat_nxt;
  logic             wr_en;
  logic [IDX_W-1:0] idx;

  // *****************************************************************
  // bus decode
  // *****************************************************************
  // only lane 0 carries register data; upper lanes are ignored
  assign idx   = adr_i[IDX_LSB +: IDX_W];
  assign wr_en = cyc_i && stb_i && we_i && !ack_r && sel_i[0];

  // one wait state: ack one cycle after the request, then drop
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_r <= 1'b0;
    else
      ack_r <= cyc_i && stb_i && !ack_r;
  end

  // read mux; unmapped indices read as zero but still ack
  always_comb
  begin
    dat_nxt = 32'h0000_0000;
    unique case (idx)
      IDX_CB_GAIN_LOW: dat_nxt[REG_W-1:0] = cb_low_r;
      IDX_CR_GAIN_LOW: dat_nxt[REG_W-1:0] = cr_low_r;
      IDX_BLACK_CB:    dat_nxt[REG_W-1:0] = black_cb_r;
      IDX_BLANK_CR:    dat_nxt[REG_W-1:0] = blank_cr_r;
      IDX_FILTER_VBI:  dat_nxt[REG_W-1:0] = filter_vbi_r;
      IDX_STD_DAC:     dat_nxt[REG_W-1:0] = std_dac_r;
      IDX_BURST_RT:    dat_nxt[REG_W-1:0] = burst_rt_r;
      default:         dat_nxt = 32'h0000_0000;
    endcase
  end

  // read data registered so the output comes straight from a flop
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_r <= 32'h0000_0000;
    else
      dat_r <= dat_nxt;
  end

  assign ack_o = ack_r;
  assign dat_o = dat_r;

  // *****************************************************************
  // gain registers
  // *****************************************************************
  // msb of each 9-bit gain lives in a level register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cb_low_r <= RST_CB_GAIN_LOW;
      cr_low_r <= RST_CR_GAIN_LOW;
    end
    else if (wr_en)
    begin
      if (idx == IDX_CB_GAIN_LOW)
        cb_low_r <= dat_i[REG_W-1:0]; // RULE4
      if (idx == IDX_CR_GAIN_LOW)
        cr_low_r <= dat_i[REG_W-1:0]; // RULE1
    end
  end

  // *****************************************************************
  // level registers
  // *****************************************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      black_cb_r   <= RST_BLACK_CB;
      blank_cr_r   <= RST_BLANK_CR;   // RULE9
      filter_vbi_r <= RST_FILTER_VBI;
    end
    else if (wr_en)
    begin
      if (idx == IDX_BLACK_CB)
        black_cb_r <= dat_i[REG_W-1:0];   // RULE6
      if (idx == IDX_BLANK_CR)
        blank_cr_r <= dat_i[REG_W-1:0];   // RULE9
      if (idx == IDX_FILTER_VBI)
        filter_vbi_r <= dat_i[REG_W-1:0]; // RULE11 RULE12
    end
  end

  // *****************************************************************
  // standard, dac and burst registers
  // *****************************************************************
  // the pal bit is kept as written even with secam set: software
  // owns that pairing, so the datapath sees exactly what was stored
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      std_dac_r  <= RST_STD_DAC;  // RULE13 RULE14 RULE18 RULE19
      burst_rt_r <= RST_BURST_RT; // RULE21 RULE23
    end
    else if (wr_en)
    begin
      if (idx == IDX_STD_DAC)
        std_dac_r <= dat_i[REG_W-1:0];  // RULE17
      if (idx == IDX_BURST_RT)
        burst_rt_r <= dat_i[REG_W-1:0]; // RULE22
    end
  end

  // *****************************************************************
  // control fields to the datapath
  // *****************************************************************
  // gain codes map straight through: code 0 nulls the subcarrier
  assign cr_chroma_gain_o = {blank_cr_r[B_GAIN_MSB], cr_low_r}; // RULE1 RULE2 RULE3
  assign cb_chroma_gain_o = {black_cb_r[B_GAIN_MSB], cb_low_r}; // RULE4
  assign black_level_o        = black_cb_r[B_LEVEL_HI:0];      // RULE6
  assign blanking_level_o     = blank_cr_r[B_LEVEL_HI:0];      // RULE9
  assign vbi_blanking_level_o = filter_vbi_r[B_LEVEL_HI:0];    // RULE12
  assign cross_color_filter_select_o =
    filter_vbi_r[B_CCF_HI:B_CCF_LO];                           // RULE11
  assign rgb_dac_down_o            = std_dac_r[B_RGB_DOWN];    // RULE13
  assign composite_dac_down_o      = std_dac_r[B_COMP_DOWN];   // RULE14
  assign luma_gain_select_o        = std_dac_r[B_LUMA_GAIN];   // RULE16
  assign secam_enable_o            = std_dac_r[B_SECAM];       // RULE17
  assign chroma_bandwidth_select_o = std_dac_r[B_CHROMA_BW];   // RULE18
  assign pal_enable_o              = std_dac_r[B_PAL];         // RULE19
  assign burst_amplitude_o      = burst_rt_r[B_BURST_HI:0];    // RULE22
  assign subcarrier_rt_enable_o = burst_rt_r[B_SC_RT_EN];      // RULE21

  // *****************************************************************
  // line length
  // *****************************************************************
  logic [9:0] line_pix_r;

  // decoded to a pixel count so the sync generator needs no table
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      line_pix_r <= LINE_PIX_LONG;
    else
      line_pix_r <= std_dac_r[B_LINE_LEN] ? LINE_PIX_SHORT
                                          : LINE_PIX_LONG; // RULE20
  end

  assign line_pixels_o = line_pix_r;

  // *****************************************************************
  // real-time control input synchroniser
  // *****************************************************************
  logic [RTC_W-1:0] rtc_s1_r;
  logic [RTC_W-1:0] rtc_s2_r;
  logic [RTC_W-1:0] rtc_s3_r;
  logic [RTC_W-1:0] rtc_stable_r;

  // a lane counts only once the second and third stages agree,
  // which rejects a single-cycle glitch at the cost of latency
  generate
    for (genvar g = 0; g < RTC_W; g++)
    begin : g_rtc_sync
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
        begin
          rtc_s1_r[g]     <= 1'b0;
          rtc_s2_r[g]     <= 1'b0;
          rtc_s3_r[g]     <= 1'b0;
          rtc_stable_r[g] <= 1'b0;
        end
        else
        begin
          rtc_s1_r[g] <= realtime_control_input_i[g];
          rtc_s2_r[g] <= rtc_s1_r[g];
          rtc_s3_r[g] <= rtc_s2_r[g];
          if (rtc_s2_r[g] == rtc_s3_r[g])
            rtc_stable_r[g] <= rtc_s3_r[g];
        end
      end
    end
  endgenerate

  // *****************************************************************
  // real-time control gating
  // *****************************************************************
  logic field_r;
  logic phase_rst_r;
  logic phase_prev_r;
  logic pal_inv_r;

  // field parity and phase reset only pass when software enables them
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      field_r      <= 1'b0;
      phase_rst_r  <= 1'b0;
      phase_prev_r <= 1'b0;
    end
    else
    begin
      field_r <= black_cb_r[B_RT_EN] && rtc_stable_r[RTC_FIELD]; // RULE5
      phase_prev_r <= rtc_stable_r[RTC_PHASE_RST];
      phase_rst_r  <= blank_cr_r[B_RT_EN]
                      && rtc_stable_r[RTC_PHASE_RST]
                      && !phase_prev_r;                          // RULE8
    end
  end

  // pal switch inversion needs both the invert bit and rt enable
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      pal_inv_r <= 1'b0;
    else
      pal_inv_r <= std_dac_r[B_PAL_INV] && burst_rt_r[B_SC_RT_EN]
                   && rtc_stable_r[RTC_PAL_SW];                  // RULE15
  end

  assign field_parity_o      = field_r;
  assign phase_reset_o       = phase_rst_r;
  assign pal_switch_invert_o = pal_inv_r;

  // *****************************************************************
  // assertions
  // *****************************************************************
  default clocking cb_clk @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_req;
    cyc_i && stb_i && !ack_r;
  endsequence

  sequence s_ack_then_drop;
    ack_o ##1 !ack_o;
  endsequence

  a_bus_ack_timing: assert property (s_req |=> s_ack_then_drop)
    else $error("ack not one cycle after request");

  a_cr_gain_write: assert property (                          // RULE1
    (wr_en && idx == IDX_CR_GAIN_LOW) |=>
      cr_chroma_gain_o[7:0] == $past(dat_i[7:0])
      && cr_chroma_gain_o[8] == $past(blank_cr_r[B_GAIN_MSB]))
    else $error("cr gain low byte not stored");

  a_cr_gain_msb: assert property (                            // RULE1
    (wr_en && idx == IDX_BLANK_CR) |=>
      cr_chroma_gain_o[8] == $past(dat_i[B_GAIN_MSB]))
    else $error("cr gain msb not from blanking register");

  a_cb_gain_msb: assert property (                            // RULE4
    (wr_en && idx == IDX_BLACK_CB) |=>
      cb_chroma_gain_o[8] == $past(dat_i[B_GAIN_MSB])
      && black_level_o == $past(dat_i[B_LEVEL_HI:0]))
    else $error("cb gain msb or black level wrong");

  a_field_gate: assert property (                             // RULE5
    !$past(black_cb_r[B_RT_EN]) |-> !field_parity_o)
    else $error("field parity passed while disabled");

  a_phase_pulse: assert property (                            // RULE8
    phase_reset_o |-> $past(blank_cr_r[B_RT_EN]) ##1 !phase_reset_o)
    else $error("phase reset not a gated single pulse");

  a_field_follow: assert property (                           // RULE5
    $past(black_cb_r[B_RT_EN]) |->
      field_parity_o == $past(rtc_stable_r[RTC_FIELD]))
    else $error("field parity does not follow enabled lane");

  a_burst_write: assert property (                            // RULE22
    (wr_en && idx == IDX_BURST_RT) |=>
      burst_amplitude_o == $past(dat_i[B_BURST_HI:0])
      && subcarrier_rt_enable_o == $past(dat_i[B_SC_RT_EN]))
    else $error("burst amplitude or rt enable not stored");

  a_pal_invert_gate: assert property (                        // RULE15
    pal_switch_invert_o |-> $past(burst_rt_r[B_SC_RT_EN])
                            && $past(std_dac_r[B_PAL_INV]))
    else $error("pal inversion without rt enable");

  a_line_length: assert property (                            // RULE20
    line_pixels_o == ($past(std_dac_r[B_LINE_LEN]) ? LINE_PIX_SHORT
                                                   : LINE_PIX_LONG))
    else $error("line length count wrong");

  a_reset_values: assert property (disable iff (1'b0)         // RULE23
    rst_i |=> std_dac_r == RST_STD_DAC && burst_rt_r == RST_BURST_RT
              && blank_cr_r == RST_BLANK_CR)
    else $error("reset values wrong");

  // checked lane by lane: one lane may settle while another moves
  a_sync_agree: assert property (
    ((rtc_stable_r ^ $past(rtc_stable_r))
     & ($past(rtc_s2_r) ^ $past(rtc_s3_r))) == '0)
    else $error("rt lane changed without agreement");

endmodule // vlg_regs

// ---- include/vlg_pkg.sv ----
// Purpose: constants for the video level and gain control register bank
// Assumes: classic wishbone, 32-bit data, one aligned word per register
// Notes:   register offsets are indices; byte address is four times index
package vlg_pkg;

  // ***************************************************************
  // bus geometry
  // ***************************************************************
  localparam int unsigned ADR_W   = 10;
  localparam int unsigned IDX_LSB = 2;
  localparam int unsigned IDX_W   = 8;
  localparam int unsigned REG_W   = 8;

  // ***************************************************************
  // register indices
  // ***************************************************************
  localparam logic [7:0] IDX_CB_GAIN_LOW = 8'h5B;
  localparam logic [7:0] IDX_CR_GAIN_LOW = 8'h5C;
  localparam logic [7:0] IDX_BLACK_CB    = 8'h5D;
  localparam logic [7:0] IDX_BLANK_CR    = 8'h5E;
  localparam logic [7:0] IDX_FILTER_VBI  = 8'h5F;
  localparam logic [7:0] IDX_STD_DAC     = 8'h61;
  localparam logic [7:0] IDX_BURST_RT    = 8'h62;

  // ***************************************************************
  // reset values
  // ***************************************************************
  localparam logic [7:0] RST_CB_GAIN_LOW = 8'h00;
  localparam logic [7:0] RST_CR_GAIN_LOW = 8'h00;
  localparam logic [7:0] RST_BLACK_CB    = 8'h00;
  localparam logic [7:0] RST_BLANK_CR    = 8'h35;
  localparam logic [7:0] RST_FILTER_VBI  = 8'h35;
  localparam logic [7:0] RST_STD_DAC     = 8'h86;
  localparam logic [7:0] RST_BURST_RT    = 8'h2F;

  // ***************************************************************
  // field positions
  // ***************************************************************
  localparam int unsigned B_GAIN_MSB  = 7;
  localparam int unsigned B_RT_EN     = 6;
  localparam int unsigned B_LEVEL_HI  = 5;
  localparam int unsigned B_CCF_HI    = 7;
  localparam int unsigned B_CCF_LO    = 6;
  localparam int unsigned B_RGB_DOWN  = 7;
  localparam int unsigned B_COMP_DOWN = 6;
  localparam int unsigned B_PAL_INV   = 5;
  localparam int unsigned B_LUMA_GAIN = 4;
  localparam int unsigned B_SECAM     = 3;
  localparam int unsigned B_CHROMA_BW = 2;
  localparam int unsigned B_PAL       = 1;
  localparam int unsigned B_LINE_LEN  = 0;
  localparam int unsigned B_SC_RT_EN  = 7;
  localparam int unsigned B_BURST_HI  = 6;

  // ***************************************************************
  // real-time control input lanes and line lengths
  // ***************************************************************
  localparam int unsigned RTC_W         = 3;
  localparam int unsigned RTC_FIELD     = 0;
  localparam int unsigned RTC_PHASE_RST = 1;
  localparam int unsigned RTC_PAL_SW    = 2;
  localparam logic [9:0]  LINE_PIX_LONG  = 10'h360;
  localparam logic [9:0]  LINE_PIX_SHORT = 10'h35A;

endpackage

// ---- sim/testbench.sv ----
// Purpose: self-checking bench for the video level and gain register bank
// Assumes: classic wishbone master driven on rising edges, seed 45791
// Notes:   expectations come from a register image kept by the bench
`timescale 1ns/100ps

module testbench
  import vlg_pkg::*;
();
  logic              clk_i    = 1'b0;
  logic              rst_i    = 1'b1;
  logic              cyc_i    = 1'b0;
  logic              stb_i    = 1'b0;
  logic              we_i     = 1'b0;
  logic [ADR_W-1:0]  adr_i    = '0;
  logic [3:0]        sel_i    = 4'h0;
  logic [31:0]       dat_i    = 32'h0;
  logic [RTC_W-1:0]  rtc_i    = '0;
  logic [31:0]       dat_o;
  logic              ack_o;
  logic [8:0]        cr_o;
  logic [8:0]        cb_o;
  logic [5:0]        black_o;
  logic [5:0]        blank_o;
  logic [5:0]        vbi_o;
  logic [1:0]        ccf_o;
  logic              rgb_o;
  logic              comp_o;
  logic              luma_o;
  logic              secam_o;
  logic              bw_o;
  logic              pal_o;
  logic [9:0]        pix_o;
  logic [6:0]        burst_o;
  logic              scrt_o;
  logic              field_o;
  logic              phase_o;
  logic              palinv_o;
  int                error_cnt  = 0;
  int                num_checks = 0;
  logic [31:0]       seed       = 32'h0000B2DF;
  logic [7:0]        m [0:255];
  logic [7:0]        tab [0:6] = '{IDX_CB_GAIN_LOW, IDX_CR_GAIN_LOW,
    IDX_BLACK_CB, IDX_BLANK_CR, IDX_FILTER_VBI, IDX_STD_DAC, IDX_BURST_RT};

  // ************************************************************
  // clock and design
  // ************************************************************
  always #25 clk_i = ~clk_i;

  vlg_regs dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .realtime_control_input_i(rtc_i), .cr_chroma_gain_o(cr_o),
    .cb_chroma_gain_o(cb_o), .black_level_o(black_o),
    .blanking_level_o(blank_o), .vbi_blanking_level_o(vbi_o),
    .cross_color_filter_select_o(ccf_o), .rgb_dac_down_o(rgb_o),
    .composite_dac_down_o(comp_o), .luma_gain_select_o(luma_o),
    .secam_enable_o(secam_o), .chroma_bandwidth_select_o(bw_o),
    .pal_enable_o(pal_o), .line_pixels_o(pix_o), .burst_amplitude_o(burst_o),
    .subcarrier_rt_enable_o(scrt_o), .field_parity_o(field_o),
    .phase_reset_o(phase_o), .pal_switch_invert_o(palinv_o));

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    v = v ^ (v << 5);
    return v;
  endfunction

  // pixels per line from the line length select bit
  function automatic logic [9:0] exp_pix(input logic b);
    return b ? 10'd858 : 10'd864;
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // one classic cycle; answer sampled at the edge where ack is seen high
  task automatic wb(input logic w, input logic [7:0] idx, d,
                    input logic s0, output logic [31:0] q);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= {idx, 2'b00};
    sel_i <= s0 ? 4'hF : 4'hE;
    dat_i <= {seed[31:8], d};
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (n >= 20)
      chk("ack", 32'h0, 32'h1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] idx, d);
    logic [31:0] q;
    wb(1'b1, idx, d, 1'b1, q);
    foreach (tab[i])
      if (tab[i] == idx)
        m[idx] = d;
  endtask

  task automatic rd(input logic [7:0] idx);
    logic [31:0] q;
    wb(1'b0, idx, 8'h00, 1'b1, q);
    chk("read", q, {24'h0, m[idx]});
  endtask

  // outputs against the image; eight cycles let the lane syncs settle
  task automatic outs;
    repeat (8) @(posedge clk_i);
    chk("cr_gain", cr_o, {m[IDX_BLANK_CR][7], m[IDX_CR_GAIN_LOW]});
    chk("cb_gain", cb_o, {m[IDX_BLACK_CB][7], m[IDX_CB_GAIN_LOW]});
    chk("black", black_o, m[IDX_BLACK_CB][5:0]);
    chk("blank", blank_o, m[IDX_BLANK_CR][5:0]);
    chk("vbi", vbi_o, m[IDX_FILTER_VBI][5:0]);
    chk("ccf", ccf_o, m[IDX_FILTER_VBI][7:6]);
    chk("rgb_down", rgb_o, m[IDX_STD_DAC][7]);
    chk("comp_down", comp_o, m[IDX_STD_DAC][6]);
    chk("luma", luma_o, m[IDX_STD_DAC][4]);
    chk("secam", secam_o, m[IDX_STD_DAC][3]);
    chk("bw", bw_o, m[IDX_STD_DAC][2]);
    chk("pal", pal_o, m[IDX_STD_DAC][1]);
    chk("pixels", pix_o, exp_pix(m[IDX_STD_DAC][0]));
    chk("burst", burst_o, m[IDX_BURST_RT][6:0]);
    chk("sc_rt", scrt_o, m[IDX_BURST_RT][7]);
    chk("field", field_o, rtc_i[0] & m[IDX_BLACK_CB][6]);
    chk("palinv", palinv_o, rtc_i[2] & m[IDX_STD_DAC][5]
        & m[IDX_BURST_RT][7]);
  endtask

  // phase reset pulses seen after a rising lane
  task automatic pulses(input logic en, input int exp);
    int c;
    wr(IDX_BLANK_CR, {1'b0, en, 6'h2E});
    rtc_i[1] <= 1'b0;
    repeat (8) @(posedge clk_i);
    rtc_i[1] <= 1'b1;
    c = 0;
    repeat (12)
    begin
      @(posedge clk_i);
      if (phase_o === 1'b1)
        c++;
    end
    chk("phase_pulses", c, exp);
  endtask

  // ************************************************************
  // watchdog and main sequence
  // ************************************************************
  initial
  begin
    #(50 * 8000);
    error_cnt++;
    end_of_test();
  end

  initial
  begin
    logic [31:0] q;
    logic [7:0]  d;
    logic [7:0]  ix;
    foreach (m[i])
      m[i] = 8'h00;
    m[IDX_BLANK_CR]   = 8'h35;
    m[IDX_FILTER_VBI] = RST_FILTER_VBI;
    m[IDX_STD_DAC]    = 8'h86;
    m[IDX_BURST_RT]   = 8'h2F;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    outs();
    foreach (tab[i])
      rd(tab[i]);
    // an unmapped place and a masked write leave the image alone
    wr(8'h60, 8'hA5);
    rd(8'h60);
    wb(1'b1, IDX_BURST_RT, 8'h55, 1'b0, q);
    rd(IDX_BURST_RT);
    // gain codes: A5h, AFh, nominal 81h, msb set over a zero low byte
    foreach (tab[i])
      if (i < 4)
      begin
        d = (i == 0) ? 8'hA5 : (i == 1) ? 8'hAF : (i == 2) ? 8'h81 : 8'h00;
        wr(IDX_CR_GAIN_LOW, d);
        wr(IDX_BLANK_CR, {i == 3, 7'h2E});
        outs();
      end
    wr(IDX_STD_DAC, 8'h08);
    wr(IDX_CR_GAIN_LOW, 8'h81);
    outs();
    for (int k = 0; k < 4; k++)
    begin
      wr(IDX_FILTER_VBI, {k[1:0], 6'h2E});
      outs();
    end
    // gating of the real-time lanes
    wr(IDX_BLACK_CB, 8'h3A);
    wr(IDX_STD_DAC, 8'h21);
    wr(IDX_BURST_RT, 8'h2F);
    rtc_i <= 3'h7;
    outs();
    wr(IDX_BURST_RT, 8'hAF);
    wr(IDX_BLACK_CB, 8'h7A);
    outs();
    pulses(1'b1, 1);
    pulses(1'b0, 0);
    // random traffic with random lanes
    for (int i = 0; i < 40; i++)
    begin
      seed = xs(seed);
      ix = tab[seed[31:16] % 7];
      d = seed[7:0];
      if (ix == IDX_STD_DAC && d[3])
        d[1] = 1'b0;
      rtc_i <= seed[10:8];
      wr(ix, d);
      rd(ix);
      outs();
    end
    end_of_test();
  end
endmodule // testbench
